//--- rtl/mdt_defs.svh
// mdt_defs.svh: frame codes, register numbers and timing figures of the
// serial management link. Assumes nothing; included by bare name.
`ifndef MDT_DEFS_SVH
`define MDT_DEFS_SVH

// frame field codes
`define MDT_START         2'h1
`define MDT_OP_READ       2'h2
`define MDT_OP_WRITE      2'h1
`define MDT_TA_WRITE      2'h2
// field lengths as last bit index, then frame bit count and bit positions
`define MDT_FIELD_LAST    4'h4
`define MDT_DATA_LAST     4'hf
`define MDT_FRAME_BITS    6'h20
`define MDT_RD_RELEASE    6'h0e
`define MDT_DATA_FIRST    6'h10
// register numbers
`define MDT_PAGE_REG      5'h1f
`define MDT_INT_CTRL_REG  5'h19
`define MDT_INT_STAT_REG  5'h1a
`define MDT_INT_EN_BIT    15
`define MDT_PAGE_RST      16'h0000
// initialisation ones before the first frame
`define MDT_INIT_ONES     2
// clock rate and management clock limit, in kHz
`define MDT_CLK_KHZ       20000
`define MDT_MDC_MAX_KHZ   12500
`define MDT_MDC_HALF_MIN  ((`MDT_CLK_KHZ + 2 * `MDT_MDC_MAX_KHZ - 1) / (2 * `MDT_MDC_MAX_KHZ))
// default half period, slow enough for the target's pin synchronisers
`define MDT_MDC_HALF_DEF  6
`define MDT_PRE_LEN_DEF   32

`endif

//--- rtl/mdt_pkg.sv
// mdt_pkg: state types of both ends of the management link.
// Does not use mdt_defs.svh; all state encodings are written here as literals.
package mdt_pkg;

    typedef enum logic [3:0]
    {
        mdt_t_init  = 4'h0,
        mdt_t_idle  = 4'h1,
        mdt_t_start = 4'h3,
        mdt_t_op    = 4'h2,
        mdt_t_phyad = 4'h6,
        mdt_t_regad = 4'h7,
        mdt_t_ta    = 4'h5,
        mdt_t_data  = 4'h4,
        mdt_t_lock  = 4'hc
    } mdt_tstate_e;

    typedef enum logic [1:0]
    {
        mdt_m_init  = 2'h0,
        mdt_m_idle  = 2'h1,
        mdt_m_pre   = 2'h3,
        mdt_m_frame = 2'h2
    } mdt_mstate_e;

endpackage

//--- rtl/mdt_if.sv
// mdt_if: the shared management wires between station manager and target.
// Resolves the open-drain data and interrupt lines with their pull-ups.
`timescale 1ns/1ps

interface mdt_if;
    logic mdc;
    logic mgr_mdio_o;
    logic mgr_mdio_oe;
    logic tgt_mdio_o;
    logic tgt_mdio_oe;
    logic tgt_int_o;
    logic tgt_int_oe;
    logic mdio;
    logic mgmt_interrupt_n;

    // wired-and with pull-up: an undriven line reads one
    assign mdio = (mgr_mdio_oe ? mgr_mdio_o : 1'b1) & (tgt_mdio_oe ? tgt_mdio_o : 1'b1);
    assign mgmt_interrupt_n = tgt_int_oe ? tgt_int_o : 1'b1;

    modport target
    (
        input  mdc,
        input  mdio,
        output tgt_mdio_o,
        output tgt_mdio_oe,
        output tgt_int_o,
        output tgt_int_oe
    );

    modport manager
    (
        output mdc,
        output mgr_mdio_o,
        output mgr_mdio_oe,
        input  mdio,
        input  mgmt_interrupt_n
    );
endinterface // mdt_if

//--- rtl/mdt_sync.sv
// mdt_sync: three-flop pin synchroniser with agreement filter.
// Assumes d is asynchronous to clk; q changes once stages two and three agree.
`timescale 1ns/1ps

module mdt_sync
#(
    parameter logic RST = 1'b0
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // pin and filtered level
    input  wire logic d,
    output logic      q
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1 <= RST;
            s2 <= RST;
            s3 <= RST;
            q  <= RST;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
            begin
                q <= s3;
            end
        end
    end
endmodule // mdt_sync

//--- rtl/mdt_target.sv
// mdt_target: management target end with paged 16-bit register set.
// Assumes mdc and mdio arrive asynchronously; mdc must stay slow enough
// for the pin synchronisers (several clk cycles per half period).
`timescale 1ns/1ps
`include "mdt_defs.svh"

// Behaviour
// - sample data on each management clock rise
// - read bits launched on rise, held one period
// - manager keeps clock at most 12.5 MHz
// - frames are 32 bits, preamble optional
// - manager sends two ones before first frame
// - idle line left undriven, pulled high
// - preamble of ones optional, any length
// - start must be 01, else ignore
// - opcode 10 read, 01 write, else ignore
// - act only on own phy address
// - next five bits give register address
// - read turnaround: release, then drive zero
// - sixteen data bits, writes sampled on rise
// - 32 registers, register 31 selects page
// - enabled interrupt pulls interrupt line low
// - data line driven open-drain only
module mdt_target
    import mdt_pkg::*;
#(
    parameter int PAGES = 4
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // management link
    mdt_if.target            link,
    // configuration and events
    input  wire logic [4:0]  phy_addr,
    input  wire logic        int_event,
    // register write report
    output logic             reg_wr_strobe,
    output logic [4:0]       reg_wr_addr,
    output logic [15:0]      reg_wr_data,
    // interrupt state
    output logic             int_pending
);
    localparam int PW = $clog2(PAGES);

    logic                mdc_f;
    logic                bit_in;
    logic                mdc_prev;
    logic                rise;
    mdt_tstate_e         state;
    logic [3:0]          cnt;
    logic [15:0]         sh;
    logic                is_rd;
    logic [4:0]          rx_phy;
    logic [4:0]          rx_reg;
    logic                hit;
    logic [15:0]         page;
    logic                page_ok;
    logic                int_en;
    logic [15:0]         rd_val;
    logic                wr_done;
    logic [15:0]         wr_val;
    logic                stat_read;
    logic [15:0]         mem [PAGES][31];

    mdt_sync #(.RST(1'b0)) u_mdc_sync
    (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (link.mdc),
        .q       (mdc_f)
    );

    mdt_sync #(.RST(1'b1)) u_mdio_sync
    (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (link.mdio),
        .q       (bit_in)
    );

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mdc_prev <= 1'b0;
        end
        else
        begin
            mdc_prev <= mdc_f;
        end
    end

    assign rise    = mdc_f & ~mdc_prev;
    assign hit     = (rx_phy == phy_addr);
    assign page_ok = (page < 16'(PAGES));
    assign wr_val  = {sh[14:0], bit_in};
    assign wr_done = rise && (state == mdt_t_data) && (cnt == `MDT_DATA_LAST)
                     && !is_rd && hit;
    assign stat_read = rise && (state == mdt_t_ta) && (cnt != 4'h0) && is_rd && hit
                       && (rx_reg == `MDT_INT_STAT_REG) && (page == `MDT_PAGE_RST);

    // read value of the addressed register in the selected page
    always_comb
    begin
        if (rx_reg == `MDT_PAGE_REG)
        begin
            rd_val = page;
        end
        else if ((rx_reg == `MDT_INT_STAT_REG) && (page == `MDT_PAGE_RST))
        begin
            rd_val = {15'h0000, int_pending};
        end
        else if (page_ok)
        begin
            rd_val = mem[page[PW-1:0]][rx_reg];
        end
        else
        begin
            rd_val = 16'h0000;
        end
    end

    // frame decoder, advanced only on management clock rises
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state  <= mdt_t_init;
            cnt    <= 4'h0;
            sh     <= 16'h0000;
            is_rd  <= 1'b0;
            rx_phy <= 5'h00;
            rx_reg <= 5'h00;
        end
        else if (rise)
        begin
            case (state)
                mdt_t_init:
                begin
                    // needs consecutive ones before any frame is trusted
                    if (!bit_in)
                    begin
                        cnt <= 4'h0;
                    end
                    else if (cnt == 4'(`MDT_INIT_ONES - 1))
                    begin
                        cnt   <= 4'h0;
                        state <= mdt_t_idle;
                    end
                    else
                    begin
                        cnt <= cnt + 4'h1;
                    end
                end
                mdt_t_idle:
                begin
                    // ones here are preamble or idle, none are required
                    if (!bit_in)
                    begin
                        state <= mdt_t_start;
                    end
                end
                mdt_t_start:
                begin
                    state <= bit_in ? mdt_t_op : mdt_t_lock;
                    cnt   <= 4'h0;
                end
                mdt_t_op:
                begin
                    if (cnt == 4'h0)
                    begin
                        sh[0] <= bit_in;
                        cnt   <= 4'h1;
                    end
                    else if ({sh[0], bit_in} == `MDT_OP_READ)
                    begin
                        is_rd <= 1'b1;
                        cnt   <= 4'h0;
                        state <= mdt_t_phyad;
                    end
                    else if ({sh[0], bit_in} == `MDT_OP_WRITE)
                    begin
                        is_rd <= 1'b0;
                        cnt   <= 4'h0;
                        state <= mdt_t_phyad;
                    end
                    else
                    begin
                        state <= mdt_t_lock;
                    end
                end
                mdt_t_phyad:
                begin
                    sh  <= wr_val;
                    cnt <= cnt + 4'h1;
                    if (cnt == `MDT_FIELD_LAST)
                    begin
                        rx_phy <= wr_val[4:0];
                        cnt    <= 4'h0;
                        state  <= mdt_t_regad;
                    end
                end
                mdt_t_regad:
                begin
                    sh  <= wr_val;
                    cnt <= cnt + 4'h1;
                    if (cnt == `MDT_FIELD_LAST)
                    begin
                        rx_reg <= wr_val[4:0];
                        cnt    <= 4'h0;
                        state  <= mdt_t_ta;
                    end
                end
                mdt_t_ta:
                begin
                    if (cnt == 4'h0)
                    begin
                        cnt <= 4'h1;
                    end
                    else
                    begin
                        sh    <= rd_val;
                        cnt   <= 4'h0;
                        state <= mdt_t_data;
                    end
                end
                mdt_t_data:
                begin
                    sh  <= wr_val;
                    cnt <= cnt + 4'h1;
                    if (cnt == `MDT_DATA_LAST)
                    begin
                        cnt   <= 4'h0;
                        state <= mdt_t_idle;
                    end
                end
                mdt_t_lock:
                begin
                    if (bit_in)
                    begin
                        state <= mdt_t_idle;
                    end
                end
                default:
                begin
                    state <= mdt_t_init;
                end
            endcase
        end
    end

    // data line driver: only ever pulls low, released outside second turnaround bit and read data
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link.tgt_mdio_o  <= 1'b0;
            link.tgt_mdio_oe <= 1'b0;
        end
        else
        begin
            link.tgt_mdio_o <= 1'b0;
            if (rise)
            begin
                if (hit && is_rd && (state == mdt_t_ta))
                begin
                    // first ta bit left free, second driven zero
                    link.tgt_mdio_oe <= (cnt == 4'h0) ? 1'b1 : ~rd_val[15];
                end
                else if (hit && is_rd && (state == mdt_t_data) && (cnt != `MDT_DATA_LAST))
                begin
                    link.tgt_mdio_oe <= ~sh[14];
                end
                else
                begin
                    link.tgt_mdio_oe <= 1'b0;
                end
            end
        end
    end

    // register store; page register lives outside the paged array
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int p = 0; p < PAGES; p++)
            begin
                for (int r = 0; r < 31; r++)
                begin
                    mem[p][r] <= 16'h0000;
                end
            end
            page          <= `MDT_PAGE_RST;
            int_en        <= 1'b0;
            reg_wr_strobe <= 1'b0;
            reg_wr_addr   <= 5'h00;
            reg_wr_data   <= 16'h0000;
        end
        else
        begin
            reg_wr_strobe <= wr_done;
            if (wr_done)
            begin
                reg_wr_addr <= rx_reg;
                reg_wr_data <= wr_val;
                if (rx_reg == `MDT_PAGE_REG)
                begin
                    page <= wr_val;
                end
                else if (page_ok)
                begin
                    mem[page[PW-1:0]][rx_reg] <= wr_val;
                end
                if ((rx_reg == `MDT_INT_CTRL_REG) && (page == `MDT_PAGE_RST))
                begin
                    int_en <= wr_val[`MDT_INT_EN_BIT];
                end
            end
        end
    end

    // interrupt: a new event beats a clearing status read
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            int_pending     <= 1'b0;
            link.tgt_int_o  <= 1'b0;
            link.tgt_int_oe <= 1'b0;
        end
        else
        begin
            if (int_event)
            begin
                int_pending <= 1'b1;
            end
            else if (stat_read)
            begin
                int_pending <= 1'b0;
            end
            link.tgt_int_o  <= 1'b0;
            link.tgt_int_oe <= int_pending & int_en;
        end
    end
endmodule // mdt_target

//--- rtl/mdt_manager.sv
// mdt_manager: station manager end; makes mdc by dividing clk and runs
// one read or write frame per request. Assumes a pull-up on mdio.
`timescale 1ns/1ps
`include "mdt_defs.svh"

module mdt_manager
    import mdt_pkg::*;
#(
    parameter int HALF    = `MDT_MDC_HALF_DEF,
    parameter int PRE_LEN = `MDT_PRE_LEN_DEF
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // management link
    mdt_if.manager           link,
    // request
    input  wire logic        req_valid,
    input  wire logic        req_read,
    input  wire logic [4:0]  req_phy,
    input  wire logic [4:0]  req_reg,
    input  wire logic [15:0] req_wdata,
    output logic             req_ready,
    // answer
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic             irq
);
    // never faster than the permitted management clock
    localparam int HP = (HALF > `MDT_MDC_HALF_MIN) ? HALF : `MDT_MDC_HALF_MIN;

    logic        mdio_f;
    logic        int_f;
    logic [7:0]  dcnt;
    logic        tick;
    logic        fall;
    logic        prerise;
    mdt_mstate_e state;
    logic [5:0]  bitn;
    logic [5:0]  cur;
    logic [31:0] fr;
    logic        rd;

    mdt_sync #(.RST(1'b1)) u_mdio_sync
    (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (link.mdio),
        .q       (mdio_f)
    );

    mdt_sync #(.RST(1'b1)) u_int_sync
    (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (link.mgmt_interrupt_n),
        .q       (int_f)
    );

    assign tick    = (dcnt == 8'(HP - 1));
    assign fall    = tick & link.mdc;
    assign prerise = tick & ~link.mdc;

    // free-running clock divider
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dcnt     <= 8'h00;
            link.mdc <= 1'b0;
            irq      <= 1'b0;
        end
        else
        begin
            dcnt <= tick ? 8'h00 : dcnt + 8'h01;
            if (tick)
            begin
                link.mdc <= ~link.mdc;
            end
            irq <= ~int_f;
        end
    end

    // frame sequencer; bits change on mdc falls, read data taken before rises
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state            <= mdt_m_init;
            bitn             <= 6'h00;
            cur              <= 6'h00;
            fr               <= 32'h0000_0000;
            rd               <= 1'b0;
            req_ready        <= 1'b0;
            rsp_valid        <= 1'b0;
            rsp_data         <= 16'h0000;
            link.mgr_mdio_o  <= 1'b1;
            link.mgr_mdio_oe <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            if (prerise && (state == mdt_m_frame) && rd && (cur >= `MDT_DATA_FIRST))
            begin
                rsp_data <= {rsp_data[14:0], mdio_f};
            end
            case (state)
                mdt_m_init:
                begin
                    if (fall)
                    begin
                        link.mgr_mdio_o  <= 1'b1;
                        link.mgr_mdio_oe <= 1'b1;
                        bitn             <= bitn + 6'h01;
                        if (bitn == 6'(`MDT_INIT_ONES))
                        begin
                            bitn             <= 6'h00;
                            link.mgr_mdio_oe <= 1'b0;
                            req_ready        <= 1'b1;
                            state            <= mdt_m_idle;
                        end
                    end
                end
                mdt_m_idle:
                begin
                    if (req_valid)
                    begin
                        rd        <= req_read;
                        fr        <= {`MDT_START, req_read ? `MDT_OP_READ : `MDT_OP_WRITE,
                                      req_phy, req_reg, `MDT_TA_WRITE, req_wdata};
                        req_ready <= 1'b0;
                        bitn      <= 6'h00;
                        cur       <= 6'h00;
                        state     <= mdt_m_pre;
                    end
                end
                mdt_m_pre:
                begin
                    if (fall)
                    begin
                        link.mgr_mdio_o  <= 1'b1;
                        link.mgr_mdio_oe <= 1'b1;
                        bitn             <= bitn + 6'h01;
                        if (bitn == 6'(PRE_LEN - 1))
                        begin
                            bitn  <= 6'h00;
                            state <= mdt_m_frame;
                        end
                    end
                end
                default:
                begin
                    if (fall)
                    begin
                        if (bitn == `MDT_FRAME_BITS)
                        begin
                            link.mgr_mdio_o  <= 1'b1;
                            link.mgr_mdio_oe <= 1'b0;
                            rsp_valid        <= rd;
                            req_ready        <= 1'b1;
                            state            <= mdt_m_idle;
                        end
                        else
                        begin
                            link.mgr_mdio_o  <= fr[31];
                            link.mgr_mdio_oe <= !(rd && (bitn >= `MDT_RD_RELEASE));
                            fr               <= {fr[30:0], 1'b0};
                            cur              <= bitn;
                            bitn             <= bitn + 6'h01;
                        end
                    end
                end
            endcase
        end
    end
endmodule // mdt_manager

//--- test/mdt_assertions.sv
// mdt_assertions: link checks between manager and target ends.
// Assumes an mdc half period of HALF clk cycles.
`timescale 1ns/1ps

module mdt_assertions
#(
    parameter int HALF = 6
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link wires
    input wire logic mdc,
    input wire logic mgr_mdio_o,
    input wire logic mgr_mdio_oe,
    input wire logic tgt_mdio_o,
    input wire logic tgt_mdio_oe,
    input wire logic tgt_int_o,
    input wire logic tgt_int_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    int hi;
    int rb;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hi <= 0;
        else
            hi <= mdc ? hi + 1 : 0;
    end
    // mdc rises since the manager let go of mdio
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rb <= 0;
        else if (mgr_mdio_oe)
            rb <= 0;
        else if ($rose(mdc))
            rb <= rb + 1;
    end
    sequence s_fall; $fell(mdc); endsequence
    sequence s_tgt_on; $rose(tgt_mdio_oe); endsequence
    property p_od; tgt_mdio_oe |-> !tgt_mdio_o; endproperty
    a_od: assert property (p_od) else $error("mdio driven high");
    property p_int_od; tgt_int_oe |-> !tgt_int_o; endproperty
    a_int_od: assert property (p_int_od) else $error("int driven high");
    property p_share; tgt_mdio_oe |-> !mgr_mdio_oe; endproperty
    a_share: assert property (p_share) else $error("both drive mdio");
    property p_launch; $changed(tgt_mdio_oe) |-> mdc; endproperty
    a_launch: assert property (p_launch) else $error("read bit off rise");
    property p_mgr; $changed(mgr_mdio_o) || $changed(mgr_mdio_oe) |-> !mdc; endproperty
    a_mgr: assert property (p_mgr) else $error("write bit not held");
    property p_hi; s_fall |-> hi == HALF; endproperty
    a_hi: assert property (p_hi) else $error("mdc high time wrong");
    property p_ta; s_tgt_on ##0 (rb <= 2) |-> rb == 1; endproperty
    a_ta: assert property (p_ta) else $error("turnaround wrong");
    property p_rel; tgt_mdio_oe |-> rb inside {[1:18]}; endproperty
    a_rel: assert property (p_rel) else $error("mdio not released");
endmodule // mdt_assertions

//--- test/tb_top.sv
// tb_top: manager and target on one link, a second target bit-banged.
// Assumes 20 MHz clk and phy address 3 on both targets.
`timescale 1ns/1ps

module tb_top;
    logic        clk, reset_n, req_valid, req_read, req_ready, rsp_valid, irq;
    logic        int_event, wr_a, wr_b, pend;
    logic [4:0]  req_phy, req_reg, wa_a, wa_b, pa = 5'h03;
    logic [15:0] req_wdata, rsp_data, wd_a, wd_b;
    int          n_mismatch = 0, compares = 0, cyc = 0;
    logic [31:0] rs = 32'h0000_9919;
    logic [20:0] rd_q[$], wa_q[$], wb_q[$];
    mdt_if link_a();
    mdt_if link_b();
    mdt_manager #(.HALF(6), .PRE_LEN(2)) i_mdt_manager
    (
        .clk(clk), .reset_n(reset_n), .link(link_a.manager), .req_valid(req_valid),
        .req_read(req_read), .req_phy(req_phy), .req_reg(req_reg), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .irq(irq)
    );
    mdt_target i_mdt_target
    (
        .clk(clk), .reset_n(reset_n), .link(link_a.target), .phy_addr(pa),
        .int_event(int_event), .reg_wr_strobe(wr_a), .reg_wr_addr(wa_a),
        .reg_wr_data(wd_a), .int_pending(pend)
    );
    mdt_target i_mdt_target_b
    (
        .clk(clk), .reset_n(reset_n), .link(link_b.target), .phy_addr(5'h03),
        .int_event(1'b0), .reg_wr_strobe(wr_b), .reg_wr_addr(wa_b),
        .reg_wr_data(wd_b), .int_pending()
    );
    mdt_assertions #(.HALF(6)) i_mdt_assertions
    (
        .clk(clk), .reset_n(reset_n), .mdc(link_a.mdc), .mgr_mdio_o(link_a.mgr_mdio_o),
        .mgr_mdio_oe(link_a.mgr_mdio_oe), .tgt_mdio_o(link_a.tgt_mdio_o),
        .tgt_mdio_oe(link_a.tgt_mdio_oe), .tgt_int_o(link_a.tgt_int_o),
        .tgt_int_oe(link_a.tgt_int_oe)
    );
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // an empty queue yields x, so an extra result always mismatches
    function automatic logic [20:0] pop(ref logic [20:0] q[$]);
        return (q.size() > 0) ? q.pop_front() : 21'hx;
    endfunction
    task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    always @(negedge clk)
    begin
        if (rsp_valid === 1'b1)
            chk("read data", pop(rd_q), {5'h00, rsp_data});
        if (wr_a === 1'b1)
            chk("write a", pop(wa_q), {wa_a, wd_a});
        if (wr_b === 1'b1)
            chk("write b", pop(wb_q), {wa_b, wd_b});
    end
    task automatic wait_ready;
        do
        begin
            @(posedge clk);
            #1;
        end
        while (req_ready !== 1'b1);
    endtask
    task automatic mreq(input logic r, input logic [4:0] g, input logic [15:0] d,
                        input logic [4:0] p);
        wait_ready();
        req_valid = 1'b1;
        req_read = r;
        req_phy = p;
        req_reg = g;
        req_wdata = d;
        @(posedge clk);
        #1 req_valid = 1'b0;
    endtask
    task automatic wr(input logic [4:0] g, input logic [15:0] d);
        wa_q.push_back({g, d});
        mreq(1'b0, g, d, 5'h03);
    endtask
    task automatic rd(input logic [4:0] g, input logic [15:0] e, input logic [4:0] p);
        rd_q.push_back({5'h00, e});
        mreq(1'b1, g, 16'h0000, p);
    endtask
    // second link: data set with the fall, mdc still between frames
    task automatic bb(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            link_b.mgr_mdio_oe = 1'b1;
            link_b.mgr_mdio_o = v[i];
            repeat (4) @(posedge clk);
            #1 link_b.mdc = 1'b1;
            repeat (4) @(posedge clk);
            #1 link_b.mdc = 1'b0;
        end
    endtask
    task automatic bw(input logic [4:0] p, input logic [4:0] g, input logic [15:0] d);
        if (p == 5'h03)
            wb_q.push_back({g, d});
        bb({2'h1, 2'h1, p, g, 2'h2, d}, 32);
    endtask
    initial
    begin
        reset_n = 1'b0;
        req_valid = 1'b0;
        req_read = 1'b0;
        req_phy = 5'h00;
        req_reg = 5'h00;
        req_wdata = 16'h0000;
        int_event = 1'b0;
        link_b.mdc = 1'b0;
        link_b.mgr_mdio_oe = 1'b0;
        link_b.mgr_mdio_o = 1'b1;
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        bb(32'h0000_0003, 2);
        bb({2'h0, 2'h1, 5'h03, 5'h07, 2'h2, 16'hffff}, 32);
        bb({2'h1, 2'h3, 5'h03, 5'h07, 2'h2, 16'hffff}, 32);
        bb({2'h1, 2'h0, 5'h03, 5'h07, 2'h2, 16'hffff}, 32);
        bw(5'h03, 5'h07, 16'ha5c3);
        bw(5'h03, 5'h1e, 16'h3c5a);
        bw(5'h04, 5'h07, 16'h0f0f);
        bw(5'h03, 5'h00, 16'h8001);
        link_b.mgr_mdio_oe = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            rs = xs(rs);
            wr({1'b0, rs[3:0]}, rs[31:16]);
            rd({1'b0, rs[3:0]}, rs[31:16], 5'h03);
        end
        wr(5'h05, 16'h1111);
        wr(5'h1f, 16'h0001);
        wr(5'h05, 16'h2222);
        rd(5'h1f, 16'h0001, 5'h03);
        rd(5'h05, 16'h2222, 5'h03);
        wr(5'h1f, 16'h0007);
        wr(5'h05, 16'h3333);
        rd(5'h05, 16'h0000, 5'h03);
        wr(5'h1f, 16'h0000);
        rd(5'h05, 16'h1111, 5'h03);
        rd(5'h05, 16'hffff, 5'h04);
        mreq(1'b0, 5'h05, 16'h4444, 5'h04);
        rd(5'h05, 16'h1111, 5'h03);
        int_event = 1'b1;
        @(posedge clk);
        #1 int_event = 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("pending", 21'h1, {20'h0, pend});
        chk("int line", 21'h1, {20'h0, link_a.mgmt_interrupt_n});
        wr(5'h19, 16'h8000);
        wait_ready();
        repeat (8) @(posedge clk);
        #1 chk("int line", 21'h0, {20'h0, link_a.mgmt_interrupt_n});
        chk("irq", 21'h1, {20'h0, irq});
        rd(5'h1a, 16'h0001, 5'h03);
        rd(5'h1a, 16'h0000, 5'h03);
        wait_ready();
        repeat (8) @(posedge clk);
        #1 chk("int line", 21'h1, {20'h0, link_a.mgmt_interrupt_n});
        chk("queues", 21'h0, 21'(rd_q.size() + wa_q.size() + wb_q.size()));
        end_sim();
    end
endmodule // tb_top
